// [rec_top.sv]
/*
   Reset escalation control: takes software and event reset requests, runs
   functional and destructive reset sequences, counts them and escalates.
   Assumes rst_n is the power-on reset, a register master that never
   overlaps strobes, and crit_event pulses from logic on clk.
*/
`timescale 1ns/100ps
`include "rec_map.svh"
module rec_top
(
   input  wire logic        clk,            // System clock, 125 MHz
   input  wire logic        rst_n,          // Power-on reset, active low
   input  wire logic [7:0]  reg_addr,       // Register byte address
   input  wire logic [31:0] reg_wdata,      // Register write data
   input  wire logic        reg_wr,         // Write strobe
   input  wire logic        reg_rd,         // Read strobe
   output logic      [31:0] reg_rdata,      // Read data, cycle after strobe
   input  wire logic        tp_reset_req,   // Test-port reset request pin
   input  wire logic [3:0]  crit_event,     // Critical event pulses
   output logic             func_reset_out, // Functional reset active
   output logic             dest_reset_out, // Destructive reset active
   output logic             lock_out        // Held until power-on
);

   // ***********************************************************************
   // Declarations
   // ***********************************************************************
   localparam logic [7:0] FUNC_HOLD_LAST = 8'(`REC_FUNC_HOLD_CYC - 1);
   localparam logic [7:0] DEST_HOLD_LAST = 8'(`REC_DEST_HOLD_CYC - 1);

   rec_pkg::rec_state_type  state_q;       // Sequencer state
   rec_pkg::rec_state_type  state_d;       // Next state
   logic [7:0]              hold_q;        // Reset pulse counter
   logic [7:0]              hold_d;        // Next pulse count
   logic                    disable_q;     // Test-port reset disable
   logic [`REC_CNT_W-1:0]   func_thr_q;    // Functional threshold
   logic [`REC_CNT_W-1:0]   dest_thr_q;    // Destructive threshold
   logic [`REC_CNT_W-1:0]   func_cnt;      // Functional reset count
   logic [`REC_CNT_W-1:0]   dest_cnt;      // Destructive reset count
   logic                    last_dest_q;   // Last sequence was destructive
   logic                    tp_sync;       // Synchronised test-port level
   logic                    tp_prev_q;     // Previous synchronised level
   logic [31:0]             rdata_d;       // Read data mux

   // ***********************************************************************
   // Register decode
   // ***********************************************************************
   wire        mode_wr     = reg_wr && (reg_addr == `REC_MODE_CONTROL_OFS);
   wire        dis_wr      = reg_wr && (reg_addr == `REC_EVENT_DISABLE_OFS);
   wire        func_thr_wr = reg_wr && (reg_addr == `REC_FUNC_THRESH_OFS);
   wire        dest_thr_wr = reg_wr && (reg_addr == `REC_DEST_THRESH_OFS);
   wire        func_cnt_wr = reg_wr && (reg_addr == `REC_FUNC_COUNT_OFS);
   wire        dest_cnt_wr = reg_wr && (reg_addr == `REC_DEST_COUNT_OFS);
   wire [3:0]  mode_code   = reg_wdata[`REC_TARGET_MODE_MSB:`REC_TARGET_MODE_LSB];
   wire [`REC_CNT_W-1:0] thr_wdata = reg_wdata[`REC_CNT_W-1:0];

   // ***********************************************************************
   // Reset causes
   // ***********************************************************************
   // Other mode codes are ordinary mode changes and start nothing here
   wire sw_func_req = mode_wr && (mode_code == `REC_MODE_FUNC);
   wire sw_dest_req = mode_wr && (mode_code == `REC_MODE_DEST);

   // Pin level is edge detected after the synchroniser only
   wire tp_rise = tp_sync && !tp_prev_q;

   // Disable gates the test-port source alone; crit_event is never masked
   wire tp_req = tp_rise && !disable_q;

   wire idle = (state_q == rec_pkg::REC_IDLE);

   // Requests during a running sequence are dropped: the device is in reset
   wire func_evt = idle && !sw_dest_req && (sw_func_req || tp_req || (|crit_event));

   // Count including this reset, one bit wider to avoid wrap
   wire [`REC_CNT_W:0] func_next = {1'b0, func_cnt} + 9'h001;
   wire [`REC_CNT_W:0] dest_next = {1'b0, dest_cnt} + 9'h001;

   // Zero threshold means escalation switched off
   wire func_esc_on = (func_thr_q != 8'h00);
   wire dest_esc_on = (dest_thr_q != 8'h00);

   // Threshold reached turns this functional reset into a destructive one
   wire func_escal = func_evt && func_esc_on && (func_next >= {1'b0, func_thr_q});

   wire dest_evt  = idle && (sw_dest_req || func_escal);
   wire dest_lock = dest_evt && dest_esc_on && (dest_next >= {1'b0, dest_thr_q});

   wire func_inc = func_evt && !func_escal;

   // Software clear, threshold write, or any destructive reset
   wire func_clr = func_cnt_wr || func_thr_wr || dest_evt;

   // Destructive resets themselves never clear this count
   wire dest_clr = dest_cnt_wr || dest_thr_wr;

   wire hold_done = (hold_q == 8'h00);

   // ***********************************************************************
   // Test-port synchroniser
   // ***********************************************************************
   rec_sync u_tp_sync
   (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in (tp_reset_req),
      .sync_out (tp_sync)
   );

   // Edge detector history
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         tp_prev_q <= 1'b0;
      else
         tp_prev_q <= tp_sync;
   end

   // ***********************************************************************
   // Reset counters
   // ***********************************************************************
   rec_counter #(.WIDTH(`REC_CNT_W)) u_func_cnt
   (
      .clk   (clk),
      .rst_n (rst_n),
      .clr   (func_clr),
      .inc   (func_inc),
      .count (func_cnt)
   );

   rec_counter #(.WIDTH(`REC_CNT_W)) u_dest_cnt
   (
      .clk   (clk),
      .rst_n (rst_n),
      .clr   (dest_clr),
      .inc   (dest_evt),
      .count (dest_cnt)
   );

   // ***********************************************************************
   // Configuration registers
   // ***********************************************************************
   // Functional threshold non-zero at reset so escalation runs unconfigured
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         disable_q  <= `REC_EVENT_DISABLE_RST;
         func_thr_q <= `REC_FUNC_THRESH_RST;
         dest_thr_q <= `REC_DEST_THRESH_RST;
      end
      else
      begin
         if (dis_wr)
            disable_q <= reg_wdata[`REC_TP_DISABLE_BIT];
         if (func_thr_wr)
            func_thr_q <= thr_wdata;
         if (dest_thr_wr)
            dest_thr_q <= thr_wdata;
      end
   end

   // ***********************************************************************
   // Sequencer
   // ***********************************************************************
   // Destructive cause wins over functional in the same cycle
   always_comb
   begin
      state_d = state_q;
      hold_d  = hold_q;
      case (state_q)
         rec_pkg::REC_IDLE:
         begin
            if (dest_lock)
               state_d = rec_pkg::REC_LOCK;
            else if (dest_evt)
            begin
               state_d = rec_pkg::REC_DEST;
               hold_d  = DEST_HOLD_LAST;
            end
            else if (func_inc)
            begin
               state_d = rec_pkg::REC_FUNC;
               hold_d  = FUNC_HOLD_LAST;
            end
         end
         rec_pkg::REC_FUNC,
         rec_pkg::REC_DEST:
         begin
            // Pulse length fixed; release back to idle at the end
            if (hold_done)
               state_d = rec_pkg::REC_IDLE;
            else
               hold_d = hold_q - 8'h01;
         end
         rec_pkg::REC_LOCK:
            state_d = rec_pkg::REC_LOCK;
         default:
         begin
            // Illegal code: fail safe into a destructive pulse
            state_d = rec_pkg::REC_DEST;
            hold_d  = DEST_HOLD_LAST;
         end
      endcase
   end

   // State and pulse counter
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_q <= rec_pkg::REC_IDLE;
         hold_q  <= 8'h00;
      end
      else
      begin
         state_q <= state_d;
         hold_q  <= hold_d;
      end
   end

   // Kind of the last sequence, for software after restart
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         last_dest_q <= 1'b0;
      else if (dest_evt)
         last_dest_q <= 1'b1;
      else if (func_inc)
         last_dest_q <= 1'b0;
   end

   // Outputs straight from one-hot state flops
   assign func_reset_out = state_q[1];
   assign dest_reset_out = state_q[2] || state_q[3];
   assign lock_out       = state_q[3];

   // ***********************************************************************
   // Read port
   // ***********************************************************************
   // Unmapped addresses read as zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      case (reg_addr)
         `REC_EVENT_DISABLE_OFS: rdata_d = {31'h0000_0000, disable_q};
         `REC_FUNC_THRESH_OFS:   rdata_d = {24'h00_0000, func_thr_q};
         `REC_DEST_THRESH_OFS:   rdata_d = {24'h00_0000, dest_thr_q};
         `REC_FUNC_COUNT_OFS:    rdata_d = {24'h00_0000, func_cnt};
         `REC_DEST_COUNT_OFS:    rdata_d = {24'h00_0000, dest_cnt};
         `REC_STATUS_OFS:        rdata_d = {26'h000_0000, func_esc_on, dest_esc_on,
                                            last_dest_q, state_q[3:1]};
         default:                rdata_d = 32'h0000_0000;
      endcase
   end

   // Data stand for one cycle only, zero otherwise
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         reg_rdata <= 32'h0000_0000;
      else if (reg_rd)
         reg_rdata <= rdata_d;
      else
         reg_rdata <= 32'h0000_0000;
   end

   // ***********************************************************************
   // Assertions
   // ***********************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   // Lock stays for eight cycles in a row
   sequence lock_held_s;
      lock_out [*8];
   endsequence

   // A destructive pulse without lock
   sequence dest_pulse_s;
      dest_reset_out && !lock_out && !func_reset_out;
   endsequence

   sw_func_start_a: assert property (
      (idle && sw_func_req && !func_escal) |=> func_reset_out && !dest_reset_out)
      else $error("software functional request did not start reset");

   sw_dest_start_a: assert property (
      (idle && sw_dest_req && !dest_lock) |=> dest_pulse_s)
      else $error("software destructive request did not start reset");

   tp_masked_a: assert property (
      (idle && tp_rise && disable_q && !mode_wr && (crit_event == 4'h0))
      |=> (state_q == rec_pkg::REC_IDLE) && (func_cnt == $past(func_cnt)))
      else $error("disabled test-port event started a reset");

   tp_enabled_a: assert property (
      (idle && tp_rise && !disable_q && !sw_dest_req) |=> !$stable(state_q))
      else $error("enabled test-port event was ignored");

   crit_unmasked_a: assert property (
      (idle && (|crit_event) && disable_q && !sw_dest_req)
      |=> (func_reset_out || dest_reset_out))
      else $error("critical event masked by test-port disable");

   func_count_a: assert property (
      (func_inc && !func_clr && (func_cnt != `REC_CNT_MAX))
      |=> func_cnt == $past(func_cnt) + 8'h01)
      else $error("functional reset not counted");

   escal_dest_a: assert property (
      (func_escal && !dest_lock) |=> dest_pulse_s ##1 dest_reset_out)
      else $error("threshold reached but no destructive reset");

   func_clear_a: assert property (
      dest_evt |=> (func_cnt == 8'h00))
      else $error("destructive reset left functional count");

   lock_hold_a: assert property (
      dest_lock |=> lock_held_s)
      else $error("destructive threshold did not hold reset");

   dest_keep_a: assert property (
      (dest_evt && !dest_clr && (dest_cnt != `REC_CNT_MAX))
      |=> (dest_cnt == $past(dest_cnt) + 8'h01) ##1 ($past(dest_clr) || dest_cnt != 8'h00))
      else $error("destructive reset disturbed its own count");

   dest_off_a: assert property (
      (dest_evt && !dest_esc_on) |=> !lock_out)
      else $error("destructive escalation active while disabled");

   func_default_a: assert property (
      (!$past(rst_n) && !$past(func_thr_wr)) |-> func_thr_q == `REC_FUNC_THRESH_RST)
      else $error("functional threshold not at default after reset");

   thr_write_a: assert property (
      (func_thr_wr && !func_inc)
      |=> (func_cnt == 8'h00) && (func_thr_q == $past(thr_wdata)))
      else $error("threshold write did not clear its counter");

endmodule

// [rec_map.svh]
/*
   Register offsets, field positions, reset values and timing counts of the
   reset escalation control block.
   Assumes one 125 MHz system clock and a 32-bit register port.
*/
`ifndef REC_MAP_SVH
`define REC_MAP_SVH

// ***********************************************************************
// Register offsets (byte addresses)
// ***********************************************************************
`define REC_MODE_CONTROL_OFS       8'h00
`define REC_EVENT_DISABLE_OFS      8'h04
`define REC_FUNC_THRESH_OFS        8'h08
`define REC_DEST_THRESH_OFS        8'h0C
`define REC_FUNC_COUNT_OFS         8'h10
`define REC_DEST_COUNT_OFS         8'h14
`define REC_STATUS_OFS             8'h18

// ***********************************************************************
// Field positions and codes
// ***********************************************************************
`define REC_TARGET_MODE_MSB        3
`define REC_TARGET_MODE_LSB        0
`define REC_MODE_FUNC              4'h0
`define REC_MODE_DEST              4'hF
`define REC_TP_DISABLE_BIT         0
`define REC_CNT_W                  8
`define REC_CNT_MAX                8'hFF

// ***********************************************************************
// Reset values
// ***********************************************************************
`define REC_EVENT_DISABLE_RST      1'h0
`define REC_FUNC_THRESH_RST        8'h0F
`define REC_DEST_THRESH_RST        8'h00

// ***********************************************************************
// Timing
// ***********************************************************************
`define REC_CLK_PERIOD_NS          8
`define REC_FUNC_HOLD_NS           400
`define REC_DEST_HOLD_NS           800
`define REC_FUNC_HOLD_CYC ((`REC_FUNC_HOLD_NS + `REC_CLK_PERIOD_NS - 1) / `REC_CLK_PERIOD_NS)
`define REC_DEST_HOLD_CYC ((`REC_DEST_HOLD_NS + `REC_CLK_PERIOD_NS - 1) / `REC_CLK_PERIOD_NS)

`endif

// [rec_pkg.sv]
/*
   Types of the reset escalation control block.
   Assumes the constants of rec_map.svh.
*/
package rec_pkg;

   // ***********************************************************************
   // Sequencer states, one-hot
   // ***********************************************************************
   typedef enum logic [3:0]
   {
      REC_IDLE = 4'h1,   // Waiting for a reset cause
      REC_FUNC = 4'h2,   // Functional reset driven
      REC_DEST = 4'h4,   // Destructive reset driven
      REC_LOCK = 4'h8    // Held in reset until power-on
   } rec_state_type;

endpackage

// [rec_sync.sv]
/*
   Two flip-flop synchroniser for one level.
   Assumes the input is asynchronous to clk.
*/
`timescale 1ns/100ps
module rec_sync
(
   input  wire logic clk,      // System clock
   input  wire logic rst_n,    // Synchronous reset, active low
   input  wire logic async_in, // Level from outside the domain
   output logic      sync_out  // Level safe to read
);

   logic meta_q;               // First stage, read only by second stage

   // ***********************************************************************
   // Two stages
   // ***********************************************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

// [rec_counter.sv]
/*
   Saturating event counter with clear.
   Assumes clear and increment are single-cycle strobes on clk.
*/
`timescale 1ns/100ps
module rec_counter
#(
   parameter int WIDTH = 8     // Counter width
)
(
   input  wire logic             clk,   // System clock
   input  wire logic             rst_n, // Synchronous reset, active low
   input  wire logic             clr,   // Clear strobe
   input  wire logic             inc,   // Count strobe
   output logic      [WIDTH-1:0] count  // Present count
);

   logic [WIDTH-1:0] count_d;          // Next count
   wire              at_max = &count;  // Saturation guard

   // Increment beats clear, so an event in the clear cycle still counts
   always_comb
   begin
      count_d = count;
      if (inc && clr)
         count_d = {{(WIDTH-1){1'b0}}, 1'b1};
      else if (clr)
         count_d = '0;
      else if (inc && !at_max)
         count_d = count + {{(WIDTH-1){1'b0}}, 1'b1};
   end

   // ***********************************************************************
   // Count register
   // ***********************************************************************
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         count <= '0;
      else
         count <= count_d;
   end

endmodule

// [test_reset_escalation_control.sv]
/*
   Self-checking bench for the reset escalation control block: a small
   integer model of the counters and thresholds gives the expected counts read
   back after every reset sequence and every software count clear.
   Assumes rec_map.svh offsets and the 50/100 cycle pulse lengths.
*/
`timescale 1ns/100ps
`include "rec_map.svh"
module test_reset_escalation_control;
   logic        clk;            // System clock
   logic        rst_n;          // Power-on reset, active low
   logic [7:0]  reg_addr;       // Register address
   logic [31:0] reg_wdata;      // Write data
   logic        reg_wr;         // Write strobe
   logic        reg_rd;         // Read strobe
   logic [31:0] reg_rdata;      // Read data
   logic        tp_reset_req;   // Test-port pin
   logic [3:0]  crit_event;     // Event pulses
   logic        func_reset_out; // Functional reset
   logic        dest_reset_out; // Destructive reset
   logic        lock_out;       // Locked
   int          error_cnt;      // Mismatches
   int          checked;        // Comparisons
   int          fcnt, dcnt, fth, dth, dis; // Model state
   int          k;              // Loop index
   logic [31:0] d;              // Read result

   rec_top uut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tp_reset_req(tp_reset_req),
      .crit_event(crit_event), .func_reset_out(func_reset_out),
      .dest_reset_out(dest_reset_out), .lock_out(lock_out));

   // 125 MHz clock
   always #4 clk = ~clk;

   // ***********************************************************************
   // Compare, bus and model tasks
   // ***********************************************************************
   task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_len(input string what, input int exp, input int got);
      checked++;
      if (got != exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // One-cycle write; the model follows the register side effects
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
      if (a == `REC_EVENT_DISABLE_OFS)
         dis = v[0];
      if (a == `REC_FUNC_THRESH_OFS)
      begin
         fth = v[7:0];
         fcnt = 0;
      end
      if (a == `REC_DEST_THRESH_OFS)
      begin
         dth = v[7:0];
         dcnt = 0;
      end
      if (a == `REC_FUNC_COUNT_OFS) fcnt = 0;
      if (a == `REC_DEST_COUNT_OFS) dcnt = 0;
   endtask

   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask

   // Model of one reset cause: 1 functional, 2 destructive, 3 lock
   function automatic int cause(input int dest);
      if (!dest)
      begin
         fcnt = fcnt + 1;
         if (fth == 0 || fcnt < fth) return 1;
         fcnt = 0;
      end
      fcnt = 0;
      if (dcnt < 255) dcnt = dcnt + 1;
      return (dth != 0 && dcnt >= dth) ? 3 : 2;
   endfunction

   // Waits a few cycles for a pulse, then measures it (lock capped at 300)
   task automatic pulse(input int kind);
      int n;
      int w;
      n = 0;
      w = 0;
      while (w < 8 && func_reset_out !== 1'b1 && dest_reset_out !== 1'b1)
      begin
         @(posedge clk);
         #1;
         w++;
      end
      while (n < 300 && ((kind == 1) ? func_reset_out : dest_reset_out) === 1'b1)
      begin
         n++;
         @(posedge clk);
         #1;
      end
      if (kind == 1) cmp_len("func pulse", `REC_FUNC_HOLD_CYC, n);
      if (kind == 2) cmp_len("dest pulse", `REC_DEST_HOLD_CYC, n);
      if (kind == 3) cmp_len("lock hold", 300, n);
      if (kind == 0) cmp_len("no pulse", 0, n + w - 8);
      cmp_word("lock_out", {31'h0, kind == 3}, {31'h0, lock_out});
      rd(`REC_FUNC_COUNT_OFS, d);
      cmp_word("func count", fcnt, d);
      rd(`REC_DEST_COUNT_OFS, d);
      cmp_word("dest count", dcnt, d);
   endtask

   task automatic evt();
      @(posedge clk);
      crit_event <= 4'($urandom % 15 + 1);
      @(posedge clk);
      crit_event <= 4'h0;
      #1;
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Whole run is under two thousand cycles
   initial
   begin
      #160000;
      error_cnt++;
      wrap_up();
   end

   // ***********************************************************************
   // Test sequence
   // ***********************************************************************
   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd, tp_reset_req, crit_event} = '0;
      error_cnt = 0;
      checked = 0;
      {fcnt, dcnt, dth, dis} = '0;
      fth = `REC_FUNC_THRESH_RST;
      void'($urandom(95504));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // Defaults: functional escalation on, destructive off
      rd(`REC_FUNC_THRESH_OFS, d);
      cmp_word("func thresh", 32'h0000000F, d);
      rd(`REC_DEST_THRESH_OFS, d);
      cmp_word("dest thresh", 32'h00000000, d);
      rd(`REC_STATUS_OFS, d);
      cmp_word("status", 32'h00000020, d);
      // Read data must fall back to zero one cycle later
      @(posedge clk);
      #1;
      cmp_word("rdata idle", 32'h00000000, reg_rdata);
      rd(`REC_MODE_CONTROL_OFS, d);
      cmp_word("mode read", 32'h00000000, d);
      rd(8'h1C, d);
      cmp_word("unmapped", 32'h00000000, d);
      $display("Test reset values done");
      // Mode codes: functional, destructive, and one ignored code
      wr(`REC_MODE_CONTROL_OFS, 32'h0);
      pulse(cause(0));
      wr(`REC_MODE_CONTROL_OFS, 32'hF);
      pulse(cause(1));
      rd(`REC_STATUS_OFS, d);
      cmp_word("last dest", 32'h00000028, d);
      wr(`REC_MODE_CONTROL_OFS, 32'h5);
      pulse(0);
      $display("Test mode codes done");
      // Disabled test-port request is dropped, enabled one runs
      wr(`REC_EVENT_DISABLE_OFS, 32'h1);
      rd(`REC_EVENT_DISABLE_OFS, d);
      cmp_word("disable", 32'h00000001, d);
      @(posedge clk);
      tp_reset_req <= 1'b1;
      pulse(0);
      @(posedge clk);
      tp_reset_req <= 1'b0;
      wr(`REC_EVENT_DISABLE_OFS, 32'h0);
      @(posedge clk);
      tp_reset_req <= 1'b1;
      pulse(cause(0));
      @(posedge clk);
      tp_reset_req <= 1'b0;
      // Critical events still reset while the test-port source is disabled
      wr(`REC_EVENT_DISABLE_OFS, 32'h1);
      evt();
      pulse(cause(0));
      $display("Test event sources done");
      // Software clears both counts with any written value
      wr(`REC_FUNC_COUNT_OFS, $urandom);
      wr(`REC_DEST_COUNT_OFS, $urandom);
      rd(`REC_FUNC_COUNT_OFS, d);
      cmp_word("func cleared", fcnt, d);
      rd(`REC_DEST_COUNT_OFS, d);
      cmp_word("dest cleared", dcnt, d);
      // Random threshold: last functional cause escalates
      wr(`REC_FUNC_THRESH_OFS, 32'($urandom % 3 + 2));
      for (k = 0; k < fth; k++)
      begin
         evt();
         pulse(cause(0));
      end
      $display("Test escalation done");
      // Destructive threshold of one locks on the next destructive reset
      wr(`REC_DEST_THRESH_OFS, 32'h1);
      rd(`REC_STATUS_OFS, d);
      cmp_word("dest esc on", 32'h00000010, d & 32'h00000010);
      wr(`REC_MODE_CONTROL_OFS, 32'hF);
      pulse(cause(1));
      evt();
      pulse(3);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      {fcnt, dcnt, dth} = '0;
      fth = `REC_FUNC_THRESH_RST;
      pulse(0);
      $display("Test lock and power-on done");
      wrap_up();
   end
endmodule
